// >>> rtl/external_memory_port_pkg.sv
package external_memory_port_pkg;

  // ==========================================================
  // Memory map and field layout.
  localparam logic [15:0] INT_TOP      = 16'h21FF;
  localparam int          SECTOR_LSB   = 13;
  localparam logic [2:0]  LIMIT_NONE   = 3'h0;
  localparam logic [3:0]  AH_LINES     = 4'h8;
  localparam int          CTL_WR       = 0;
  localparam int          CTL_RD       = 1;
  localparam int          CTL_ALE      = 2;

  // ==========================================================
  // Reset values and constants.
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;
  localparam logic [7:0]  BYTE_ONES    = 8'hFF;
  localparam logic [1:0]  WAIT_ZERO    = 2'h0;
  localparam logic [1:0]  PEND_ZERO    = 2'h0;
  localparam logic [15:0] ADDR_ZERO    = 16'h0000;

  // ==========================================================
  // Sequencer states.
  typedef enum logic [2:0] {ST_IDLE, ST_INT, ST_ADDR, ST_DATA, ST_END} external_memory_port_state_type;

endpackage : external_memory_port_pkg

// >>> rtl/external_memory_port_sector_decode.sv
module external_memory_port_sector_decode
  import external_memory_port_pkg::*;
(
  // Access address.
  input  wire logic [15:0] i_addr,
  // Sector and wait configuration.
  input  wire logic [2:0]  i_sector_limit,
  input  wire logic [1:0]  i_wait_lower,
  input  wire logic [1:0]  i_wait_upper,
  // Decode results.
  output logic             o_external,
  output logic             o_upper,
  output logic [1:0]       o_wait
);

  // ==========================================================
  // Internal or external target, sector and wait selection.
  always_comb begin
    o_external = (i_addr > INT_TOP);
    o_upper    = (i_sector_limit != LIMIT_NONE) &&
                 (i_addr[15:SECTOR_LSB] >= i_sector_limit);
    o_wait     = o_upper ? i_wait_upper : i_wait_lower;
  end

endmodule : external_memory_port_sector_decode

// >>> rtl/external_memory_port_pin_mux.sv
module external_memory_port_pin_mux
  import external_memory_port_pkg::*;
(
  // Interface enable and drive request.
  input  wire logic       i_en,
  input  wire logic       i_ad_drv,
  input  wire logic [7:0] i_ad_val,
  input  wire logic [7:0] i_ah_val,
  input  wire logic [2:0] i_release,
  // Normal port settings.
  input  wire logic [7:0] i_port_ad_out,
  input  wire logic [7:0] i_port_ad_dir,
  input  wire logic [7:0] i_port_ah_out,
  input  wire logic [7:0] i_port_ah_dir,
  // Pin values.
  output logic [7:0]      o_ad_out,
  output logic [7:0]      o_ad_oe,
  output logic [7:0]      o_ah_out,
  output logic [7:0]      o_ah_oe
);

  // ==========================================================
  // Per-line override of the port settings.
  for (genvar i = 0; i < 8; i++) begin : g_line
    localparam logic [3:0] BIT_IDX = 4'(i);
    logic used;
    assign used        = i_en && ((BIT_IDX + {1'b0, i_release}) < AH_LINES);
    assign o_ad_out[i] = i_en ? i_ad_val[i] : i_port_ad_out[i];
    assign o_ad_oe[i]  = i_en ? i_ad_drv : i_port_ad_dir[i];
    assign o_ah_out[i] = used ? i_ah_val[i] : i_port_ah_out[i];
    assign o_ah_oe[i]  = used ? 1'b1 : i_port_ah_dir[i];
  end

endmodule : external_memory_port_pin_mux

// >>> rtl/external_memory_bus_interface.sv
// Summary of operation
// - Enabled, addresses above internal SRAM go out on the external pins.
// - Low address byte and data byte share the eight muxed low lines.
// - Upper address on separate lines, number of used lines configurable.
// - Enabled interface overrides port direction on all its pins.
// - Address alone decides internal or external target per access.
// - External access drives address, data and strobes in fixed sequence.
// - Low address is valid on the muxed lines when the latch strobe falls.
// - Latch strobe stays low through the data phase.
// - Internal accesses may toggle address and latch strobe, never read/write.
// - Disabled interface gives the pins back to the normal port settings.
// - Disabled, addresses above internal SRAM never alias into it.
// - Four software wait-state choices including zero.
// - Two sectors with configurable boundary, each with own wait setting.
// - Software-enabled bus keeper on the muxed low lines.
// - External accesses only happen once the enable bit is set.
// - Zero-wait external access takes one cycle more than internal.
// - One, two, three waits add one, two, three cycles.
// - Enabled keeper holds last driven value while the enabled interface releases the lines.
module external_memory_bus_interface
  import external_memory_port_pkg::*;
(
  // Clock and reset.
  input  wire logic        I_CLOCK,
  input  wire logic        I_SYS_RST,
  // Configuration.
  input  wire logic        I_EXT_SRAM_ENABLE,
  input  wire logic        I_KEEPER_ENABLE,
  input  wire logic [2:0]  I_SECTOR_LIMIT,
  input  wire logic [1:0]  I_WAIT_LOWER,
  input  wire logic [1:0]  I_WAIT_UPPER,
  input  wire logic [2:0]  I_ADDR_RELEASE,
  // Access request.
  input  wire logic        I_REQ,
  input  wire logic        I_WRITE,
  input  wire logic [15:0] I_ADDR,
  input  wire logic [7:0]  I_WDATA,
  // Access answer.
  output logic             O_ACK,
  output logic             O_BUSY,
  output logic             O_INT_SEL,
  output logic             O_UNMAPPED,
  output logic [7:0]       O_RDATA,
  output logic             O_RVALID,
  // Normal port settings.
  input  wire logic [7:0]  I_PORT_AD_OUT,
  input  wire logic [7:0]  I_PORT_AD_DIR,
  input  wire logic [7:0]  I_PORT_AH_OUT,
  input  wire logic [7:0]  I_PORT_AH_DIR,
  input  wire logic [2:0]  I_PORT_CTL_OUT,
  input  wire logic [2:0]  I_PORT_CTL_DIR,
  // Muxed low lines.
  input  wire logic [7:0]  I_AD_IN,
  output logic [7:0]       O_AD_OUT,
  output logic [7:0]       O_AD_OE,
  output logic             O_KEEP_EN,
  output logic [7:0]       O_KEEP_VAL,
  // Upper address lines.
  output logic [7:0]       O_AH_OUT,
  output logic [7:0]       O_AH_OE,
  // Strobes.
  output logic             O_ALE,
  output logic             O_ALE_OE,
  output logic             O_RD_N,
  output logic             O_RD_OE,
  output logic             O_WR_N,
  output logic             O_WR_OE
);

  // ==========================================================
  // Declarations.
  external_memory_port_state_type state_r, state_nxt;
  logic [1:0]     cnt_r, cnt_nxt;
  logic [15:0]    addr_r, addr_nxt;
  logic [7:0]     wdata_r, wdata_nxt;
  logic           write_r, write_nxt, ack_nxt, unm_nxt, int_nxt;
  logic [1:0]     pend_r, pend_nxt, wait_sel;
  logic [7:0]     rdata_nxt, ad_s1_r, ad_s2_r;
  logic           is_ext, is_upper, ale_c, rd_n_c, wr_n_c, ad_drv_c;
  logic [7:0]     ad_val_c, keep_val_nxt;
  logic [7:0]     ad_out_c, ad_oe_c, ah_out_c, ah_oe_c;
  logic           ale_nxt, ale_oe_nxt, rd_n_nxt, rd_oe_nxt, wr_n_nxt, wr_oe_nxt, keep_en_nxt;

  // ==========================================================
  // Decode and pin override.
  external_memory_port_sector_decode u_decode (
    .i_addr         (I_ADDR),
    .i_sector_limit (I_SECTOR_LIMIT),
    .i_wait_lower   (I_WAIT_LOWER),
    .i_wait_upper   (I_WAIT_UPPER),
    .o_external     (is_ext),
    .o_upper        (is_upper),
    .o_wait         (wait_sel)
  );
  external_memory_port_pin_mux u_mux (
    .i_en          (I_EXT_SRAM_ENABLE),
    .i_ad_drv      (ad_drv_c),
    .i_ad_val      (ad_val_c),
    .i_ah_val      (addr_nxt[15:8]),
    .i_release     (I_ADDR_RELEASE),
    .i_port_ad_out (I_PORT_AD_OUT),
    .i_port_ad_dir (I_PORT_AD_DIR),
    .i_port_ah_out (I_PORT_AH_OUT),
    .i_port_ah_dir (I_PORT_AH_DIR),
    .o_ad_out      (ad_out_c),
    .o_ad_oe       (ad_oe_c),
    .o_ah_out      (ah_out_c),
    .o_ah_oe       (ah_oe_c)
  );

  // ==========================================================
  // Access sequencer and pin controls for the coming cycle.
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    addr_nxt  = addr_r;
    wdata_nxt = wdata_r;
    write_nxt = write_r;
    ack_nxt   = 1'b0;
    unm_nxt   = 1'b0;
    int_nxt   = 1'b0;
    pend_nxt  = {pend_r[0], 1'b0};
    rdata_nxt = pend_r[1] ? ad_s2_r : O_RDATA;
    case (state_r)
      ST_IDLE: begin
        if (I_REQ) begin
          addr_nxt  = I_ADDR;
          wdata_nxt = I_WDATA;
          write_nxt = I_WRITE;
          cnt_nxt   = wait_sel;
          if (!is_ext) begin
            state_nxt = ST_INT;
            int_nxt   = 1'b1;
          end else if (I_EXT_SRAM_ENABLE) begin
            state_nxt = ST_ADDR;
          end else begin
            ack_nxt = 1'b1;
            unm_nxt = 1'b1;
          end
        end
      end
      ST_INT: begin
        ack_nxt   = 1'b1;
        state_nxt = ST_IDLE;
      end
      ST_ADDR: begin
        state_nxt = ST_DATA;
      end
      ST_DATA: begin
        if (cnt_r == WAIT_ZERO) begin
          state_nxt   = ST_END;
          ack_nxt     = 1'b1;
          pend_nxt[0] = !write_r;
        end else begin
          cnt_nxt = cnt_r - 2'h1;
        end
      end
      ST_END: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_comb begin
    ale_c    = (state_nxt == ST_INT) || (state_nxt == ST_ADDR);
    rd_n_c   = !((state_nxt == ST_DATA) && !write_nxt);
    wr_n_c   = !((state_nxt == ST_DATA) && write_nxt);
    ad_drv_c = ale_c || (((state_nxt == ST_DATA) || (state_nxt == ST_END)) && write_nxt);
    ad_val_c = ale_c ? addr_nxt[7:0] : wdata_nxt;
    if (I_EXT_SRAM_ENABLE) begin
      ale_nxt    = ale_c;
      rd_n_nxt   = rd_n_c;
      wr_n_nxt   = wr_n_c;
      ale_oe_nxt = 1'b1;
      rd_oe_nxt  = 1'b1;
      wr_oe_nxt  = 1'b1;
    end else begin
      ale_nxt    = I_PORT_CTL_OUT[CTL_ALE];
      rd_n_nxt   = I_PORT_CTL_OUT[CTL_RD];
      wr_n_nxt   = I_PORT_CTL_OUT[CTL_WR];
      ale_oe_nxt = I_PORT_CTL_DIR[CTL_ALE];
      rd_oe_nxt  = I_PORT_CTL_DIR[CTL_RD];
      wr_oe_nxt  = I_PORT_CTL_DIR[CTL_WR];
    end
    keep_en_nxt  = I_KEEPER_ENABLE && I_EXT_SRAM_ENABLE && !ad_drv_c;
    keep_val_nxt = (I_EXT_SRAM_ENABLE && ad_drv_c) ? ad_val_c : O_KEEP_VAL;
  end

  // ==========================================================
  // Registers.
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      state_r    <= ST_IDLE;
      cnt_r      <= WAIT_ZERO;
      addr_r     <= ADDR_ZERO;
      wdata_r    <= BYTE_ZERO;
      write_r    <= 1'b0;
      pend_r     <= PEND_ZERO;
      ad_s1_r    <= BYTE_ZERO;
      ad_s2_r    <= BYTE_ZERO;
      O_ACK      <= 1'b0;
      O_BUSY     <= 1'b0;
      O_INT_SEL  <= 1'b0;
      O_UNMAPPED <= 1'b0;
      O_RDATA    <= BYTE_ZERO;
      O_RVALID   <= 1'b0;
      O_AD_OUT   <= BYTE_ZERO;
      O_AD_OE    <= BYTE_ZERO;
      O_KEEP_EN  <= 1'b0;
      O_KEEP_VAL <= BYTE_ZERO;
      O_AH_OUT   <= BYTE_ZERO;
      O_AH_OE    <= BYTE_ZERO;
      O_ALE      <= 1'b0;
      O_ALE_OE   <= 1'b0;
      O_RD_N     <= 1'b1;
      O_RD_OE    <= 1'b0;
      O_WR_N     <= 1'b1;
      O_WR_OE    <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      cnt_r      <= cnt_nxt;
      addr_r     <= addr_nxt;
      wdata_r    <= wdata_nxt;
      write_r    <= write_nxt;
      pend_r     <= pend_nxt;
      ad_s1_r    <= I_AD_IN;
      ad_s2_r    <= ad_s1_r;
      O_ACK      <= ack_nxt;
      O_BUSY     <= (state_nxt != ST_IDLE);
      O_INT_SEL  <= int_nxt;
      O_UNMAPPED <= unm_nxt;
      O_RDATA    <= rdata_nxt;
      O_RVALID   <= pend_r[1];
      O_AD_OUT   <= ad_out_c;
      O_AD_OE    <= ad_oe_c;
      O_KEEP_EN  <= keep_en_nxt;
      O_KEEP_VAL <= keep_val_nxt;
      O_AH_OUT   <= ah_out_c;
      O_AH_OE    <= ah_oe_c;
      O_ALE      <= ale_nxt;
      O_ALE_OE   <= ale_oe_nxt;
      O_RD_N     <= rd_n_nxt;
      O_RD_OE    <= rd_oe_nxt;
      O_WR_N     <= wr_n_nxt;
      O_WR_OE    <= wr_oe_nxt;
    end
  end

  // ==========================================================
  // Checks.
  property p_strobe_idle;
    @(posedge I_CLOCK) disable iff (I_SYS_RST)
      $past(I_EXT_SRAM_ENABLE) && (state_r != ST_DATA) |-> O_RD_N && O_WR_N;
  endproperty
  a_strobe_idle: assert property (p_strobe_idle)
    else $error("Strobe active outside data phase.");

  property p_zero_wait;
    @(posedge I_CLOCK) disable iff (I_SYS_RST)
      (state_r == ST_IDLE) && I_REQ && I_EXT_SRAM_ENABLE && is_ext && (wait_sel == 2'h0)
      |-> ##1 !O_ACK [*2] ##1 O_ACK;
  endproperty
  a_zero_wait: assert property (p_zero_wait)
    else $error("Zero-wait external access not three cycles.");

  property p_three_wait;
    @(posedge I_CLOCK) disable iff (I_SYS_RST)
      (state_r == ST_IDLE) && I_REQ && I_EXT_SRAM_ENABLE && is_ext && (wait_sel == 2'h3)
      |-> ##1 !O_ACK [*5] ##1 O_ACK;
  endproperty
  a_three_wait: assert property (p_three_wait)
    else $error("Three-wait external access not six cycles.");

  property p_internal;
    @(posedge I_CLOCK) disable iff (I_SYS_RST)
      (state_r == ST_IDLE) && I_REQ && I_EXT_SRAM_ENABLE && !is_ext
      |=> O_ALE && O_INT_SEL ##1 !O_ALE && O_ACK && O_RD_N && O_WR_N;
  endproperty
  a_internal: assert property (p_internal)
    else $error("Internal access sequence wrong.");

  property p_latch;
    @(posedge I_CLOCK) disable iff (I_SYS_RST)
      $past(I_EXT_SRAM_ENABLE) && (state_r == ST_ADDR)
      |-> O_ALE && (O_AD_OE == BYTE_ONES) && (O_AD_OUT == addr_r[7:0]) ##1 !O_ALE;
  endproperty
  a_latch: assert property (p_latch)
    else $error("Low address not valid at latch strobe fall.");

  property p_ale_low;
    @(posedge I_CLOCK) disable iff (I_SYS_RST)
      $past(I_EXT_SRAM_ENABLE) && (state_r == ST_DATA) |-> !O_ALE;
  endproperty
  a_ale_low: assert property (p_ale_low)
    else $error("Latch strobe high during data phase.");

  property p_read_release;
    @(posedge I_CLOCK) disable iff (I_SYS_RST)
      $past(I_EXT_SRAM_ENABLE) && (state_r == ST_DATA) && !write_r |-> (O_AD_OE == BYTE_ZERO) && !O_RD_N;
  endproperty
  a_read_release: assert property (p_read_release)
    else $error("Muxed lines driven during read data phase.");

  property p_disabled;
    @(posedge I_CLOCK) disable iff (I_SYS_RST)
      !$past(I_EXT_SRAM_ENABLE) |-> (O_AD_OUT == $past(I_PORT_AD_OUT)) && (O_AD_OE == $past(I_PORT_AD_DIR));
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("Disabled pins differ from port settings.");

  property p_no_alias;
    @(posedge I_CLOCK) disable iff (I_SYS_RST)
      (state_r == ST_IDLE) && I_REQ && !I_EXT_SRAM_ENABLE && is_ext |=> O_ACK && O_UNMAPPED && !O_INT_SEL;
  endproperty
  a_no_alias: assert property (p_no_alias)
    else $error("Disabled external address reached internal memory.");

  property p_keeper;
    @(posedge I_CLOCK) disable iff (I_SYS_RST)
      O_KEEP_EN && $past(O_KEEP_EN) |-> $stable(O_KEEP_VAL) && (O_AD_OE == BYTE_ZERO);
  endproperty
  a_keeper: assert property (p_keeper)
    else $error("Keeper value moved while lines released.");

  property p_sector;
    @(posedge I_CLOCK) disable iff (I_SYS_RST)
      is_upper |-> (wait_sel == I_WAIT_UPPER) && (I_ADDR[15:13] >= I_SECTOR_LIMIT);
  endproperty
  a_sector: assert property (p_sector)
    else $error("Upper sector wait setting not used.");

endmodule : external_memory_bus_interface

// >>> dv/external_memory_port_far_side.sv
// ==========================================================
// Address latch plus byte memory on the far side of the pins.
module external_memory_port_far_side (
  // Pins from the interface.
  input  wire logic       clk,
  input  wire logic [7:0] ad_out,
  input  wire logic [7:0] ad_oe,
  input  wire logic [7:0] ah,
  input  wire logic       ale,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic       keep_en,
  input  wire logic [7:0] keep_val,
  // Access delay in cycles.
  input  wire logic [1:0] lag,
  // Wire level of the muxed lines.
  output logic [7:0]      ad_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:65535];
  logic [7:0] low_q;
  logic [7:0] lat_q;
  logic [7:0] last = 8'h00;
  logic [1:0] cnt  = 2'h0;
  logic       drv;
  // Holds the address seen before the edge on which the gate falls, as the latch hold time does.
  always @(posedge clk) begin
    if (ale) low_q <= ad_out;
  end
  assign lat_q = ale ? ad_out : low_q;
  always @(posedge clk) begin
    cnt <= (rd_n === 1'b0) ? cnt + 2'h1 : 2'h0;
    if (wr_n === 1'b0) mem[{ah, lat_q}] <= ad_in;
    last <= ad_in;
  end
  // Data shows only once the access time has run; before that the keeper value shows, or the line drifts with the keeper off.
  assign drv = (rd_n === 1'b0) && (cnt >= lag);
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      ad_in[i] = ad_oe[i] ? ad_out[i] : drv ? mem[{ah, lat_q}][i] : keep_en ? keep_val[i] : ~last[i];
    end
  end
endmodule // external_memory_port_far_side

// >>> dv/tb_external_memory_bus_interface.sv
// ==========================================================
// Self-checking bench.
module tb_external_memory_bus_interface
  import external_memory_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst, en, keep, req, wr;
  logic [2:0]  lim, rel;
  logic [1:0]  wlo, wup, lag;
  logic [15:0] addr;
  logic [7:0]  wd, p_ado, p_add, p_aho, p_ahd, ad_in;
  logic        ack, busy, isel, unm_o, rvalid, keep_en, ale, ale_oe, rd_n, rd_oe, wr_n, wr_oe;
  logic [7:0]  rdata, ad_out, ad_oe, keep_val, ah_out, ah_oe;
  logic [12:0] ale_h, rd_h, wr_h;
  logic [7:0]  ad_h [13];
  logic [7:0]  oe_h [13];
  logic [7:0]  ah_h [13];
  int          ack_at, rv_at, int_at, bsy_at, unm, mismatches, n_tests;

  external_memory_bus_interface uut (.I_CLOCK(clk), .I_SYS_RST(rst), .I_EXT_SRAM_ENABLE(en),
    .I_KEEPER_ENABLE(keep), .I_SECTOR_LIMIT(lim), .I_WAIT_LOWER(wlo), .I_WAIT_UPPER(wup),
    .I_ADDR_RELEASE(rel), .I_REQ(req), .I_WRITE(wr), .I_ADDR(addr), .I_WDATA(wd), .O_ACK(ack),
    .O_BUSY(busy), .O_INT_SEL(isel), .O_UNMAPPED(unm_o), .O_RDATA(rdata), .O_RVALID(rvalid),
    .I_PORT_AD_OUT(p_ado), .I_PORT_AD_DIR(p_add), .I_PORT_AH_OUT(p_aho), .I_PORT_AH_DIR(p_ahd),
    .I_PORT_CTL_OUT(3'h7), .I_PORT_CTL_DIR(3'h5), .I_AD_IN(ad_in), .O_AD_OUT(ad_out), .O_AD_OE(ad_oe),
    .O_KEEP_EN(keep_en), .O_KEEP_VAL(keep_val), .O_AH_OUT(ah_out), .O_AH_OE(ah_oe), .O_ALE(ale),
    .O_ALE_OE(ale_oe), .O_RD_N(rd_n), .O_RD_OE(rd_oe), .O_WR_N(wr_n), .O_WR_OE(wr_oe));
  external_memory_port_far_side far (.clk(clk), .ad_out(ad_out), .ad_oe(ad_oe), .ah(ah_out), .ale(ale), .rd_n(rd_n),
    .wr_n(wr_n), .keep_en(keep_en), .keep_val(keep_val), .lag(lag), .ad_in(ad_in));

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One request, then twelve cycles of pin history; sample n follows the n-th edge, the taking edge first.
  task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    req = 1'b1; wr = w; addr = a; wd = d;
    ack_at = 0; rv_at = 0; int_at = 0; bsy_at = 0; unm = 0; ale_h = '0; rd_h = '1; wr_h = '1;
    for (int n = 1; n <= 12; n++) begin
      @(negedge clk);
      req = 1'b0;
      ale_h[n] = ale; rd_h[n] = rd_n; wr_h[n] = wr_n; ad_h[n] = ad_out; oe_h[n] = ad_oe; ah_h[n] = ah_out;
      if (busy === 1'b1) bsy_at = n;
      if (ack === 1'b1) ack_at = n;
      if (rvalid === 1'b1) rv_at = n;
      if (isel === 1'b1) int_at = n;
      if (unm_o === 1'b1) unm = 1;
    end
  endtask

  task automatic t_write;
    xfer(1'b1, 16'h4321, 8'hA5);
    chk("ale_hi", ale_h[2:1], 2'b01);
    chk("ad_addr", ad_h[1], 8'h21);
    chk("ad_data", ad_h[2], 8'hA5);
    chk("ah", ah_h[1], 8'h43);
    chk("wr_strobe", wr_h, 13'h1FFB);
    chk("ack", ack_at, 3);
    chk("busy_end", bsy_at, 3);
    chk("mem", far.mem[16'h4321], 8'hA5);
  endtask

  task automatic t_reads;
    for (int w = 0; w < 4; w++) begin
      wlo = w[1:0]; lag = w[1:0];
      far.mem[16'h5000 + w] = 8'h3C + w;
      xfer(1'b0, 16'(16'h5000 + w), 8'h00);
      chk("ack_w", ack_at, 3 + w);
      chk("rvalid", rv_at, 5 + w);
      chk("rdata", rdata, 8'h3C + w);
      chk("rd_release", oe_h[2], 8'h00);
      chk("rd_low", rd_h[2], 1'b0);
    end
    wlo = 2'h0; lag = 2'h0;
  endtask

  task automatic t_sectors;
    lim = 3'h4; wup = 2'h3;
    xfer(1'b1, 16'h7FFF, 8'h11);
    chk("lower_sec", ack_at, 3);
    xfer(1'b1, 16'h8000, 8'h22);
    chk("upper_sec", ack_at, 6);
    lim = 3'h0;
  endtask

  task automatic t_internal;
    xfer(1'b0, INT_TOP, 8'h00);
    chk("int_ack", ack_at, 2);
    chk("int_sel", int_at, 1);
    chk("int_rd", rd_h & wr_h, 13'h1FFF);
    xfer(1'b1, 16'h2200, 8'h77);
    chk("ext_edge", ack_at, 3);
    chk("ext_mem", far.mem[16'h2200], 8'h77);
  endtask

  task automatic t_disabled;
    en = 1'b0;
    xfer(1'b1, 16'h2201, 8'h99);
    chk("unm", unm, 1);
    chk("unm_ack", ack_at, 1);
    chk("no_wr", wr_h, 13'h1FFF);
    chk("ad_port", {ad_out, ad_oe}, 16'h960F);
    chk("ah_port", {ah_out, ah_oe}, 16'hC35A);
    chk("ctl_port", {ale, rd_n, wr_n, ale_oe, rd_oe, wr_oe}, 6'h3D);
    en = 1'b1;
  endtask

  task automatic t_release;
    rel = 3'h2;
    xfer(1'b1, 16'h2345, 8'h33);
    chk("ah_rel", ah_h[1], 8'hE3);
    chk("ah_oe", ah_oe, 8'h7F);
    chk("ctl_oe", {ale_oe, rd_oe, wr_oe}, 3'h7);
    rel = 3'h0;
  endtask

  task automatic t_keeper;
    keep = 1'b1;
    xfer(1'b1, 16'h6000, 8'h5B);
    chk("keep_en", keep_en, 1'b1);
    chk("keep_val", keep_val, 8'h5B);
    keep = 1'b0;
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    #100000;
    mismatches++;
    close_out();
  end

  initial begin
    mismatches = 0; n_tests = 0;
    rst = 1'b1; en = 1'b1; keep = 1'b0; req = 1'b0; wr = 1'b0; lim = 3'h0; rel = 3'h0;
    wlo = 2'h0; wup = 2'h0; lag = 2'h0; addr = 16'h0000; wd = 8'h00;
    p_ado = 8'h96; p_add = 8'h0F; p_aho = 8'hC3; p_ahd = 8'h5A;
    repeat (20) @(negedge clk);
    chk("rst_strobes", {rd_n, wr_n, ack, busy, ad_oe}, 12'hC00);
    rst = 1'b0;
    t_write();
    t_reads();
    t_sectors();
    t_internal();
    t_disabled();
    t_release();
    t_keeper();
    close_out();
  end
endmodule // tb_external_memory_bus_interface
